// file: rtl/lpwt_top.sv
// Low power wake timer: 24-bit slow counter with compare, wake, DMA trigger and capture.
`timescale 1ns/1ns
module lpwt_top #(
    parameter int CNT_W = lpwt_pkg::LPWT_CNT_W
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic slow_clk_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [7:0] port0_pin_irq_flags_i,
    input wire logic [7:0] port1_pin_irq_flags_i,
    input wire logic [5:0] port2_pin_irq_flags_i,
    input wire lpwt_pkg::lpwt_pmode_t power_mode_i,
    input wire logic wake_timer_irq_enable_i,
    input wire logic wake_timer_irq_clear_i,
    output logic wake_timer_irq_flag_o,
    output logic wake_timer_irq_o,
    output logic dma_trigger_o,
    output logic wake_request_o,
    output logic slow_clock_level_bit_o
);
    import lpwt_pkg::*;

    logic slow_level;
    logic slow_rise;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] snapshot;
    logic [CNT_W-1:0] compare;
    logic [7:0] wr_mid;
    logic [7:0] wr_high;
    logic load_ready_bit;
    logic [CNT_W-1:0] load_value;
    logic [1:0] load_ticks;
    logic [1:0] cap_port;
    logic [2:0] cap_pin;
    logic cap_valid;
    logic [CNT_W-1:0] captured_value;
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    logic pin_seen;
    logic cmp_hit;
    logic cmp_prev;
    logic cmp_event;
    logic cap_event;
    logic wr_low;
    logic running;

    // Decodes the capture select into a single pin flag, or zero when disabled.
    function automatic logic pin_flag(input logic [1:0] port, input logic [2:0] pin,
                                      input logic [7:0] p0, input logic [7:0] p1,
                                      input logic [5:0] p2);
        pin_flag = 1'b0;
        if (port == 2'h0) begin
            pin_flag = p0[pin];
        end else if (port == 2'h1) begin
            pin_flag = p1[pin];
        end else if (port == LPWT_PORT_LAST_NARROW && pin <= LPWT_PIN_MAX_NARROW) begin
            pin_flag = p2[pin];
        end
    endfunction

    // ==========================================================
    // Slow clock crossing
    lpwt_slow_edge u_slow_edge (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .slow_clk_i(slow_clk_i),
        .level_o(slow_level),
        .rise_o(slow_rise)
    );

    assign running = (power_mode_i != LPWT_PM_DEEPEST);
    assign wr_low = reg_wr_i && (reg_addr_i == LPWT_OFF_CNT_LOW);

    // ==========================================================
    // Counter
    // The deepest mode removes power; the count is cleared and held at zero there.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count <= '0;
        end else if (!running) begin
            count <= '0;
        end else if (slow_rise) begin
            count <= count + 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            snapshot <= '0;
        end else if (reg_rd_i && reg_addr_i == LPWT_OFF_CNT_LOW) begin
            snapshot <= count;
        end
    end

    // ==========================================================
    // Compare load handshake
    // The load completes on the slow side, so ready drops for a couple of ticks.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_mid <= '0;
            wr_high <= '0;
        end else if (reg_wr_i && reg_addr_i == LPWT_OFF_CNT_MID) begin
            wr_mid <= reg_wdata_i;
        end else if (reg_wr_i && reg_addr_i == LPWT_OFF_CNT_HIGH) begin
            wr_high <= reg_wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            load_ready_bit <= 1'b1;
            load_value <= LPWT_CMP_RESET;
            load_ticks <= '0;
            compare <= LPWT_CMP_RESET;
        end else if (load_ready_bit) begin
            if (wr_low) begin
                load_value <= {wr_high, wr_mid, reg_wdata_i};
                load_ready_bit <= 1'b0;
                load_ticks <= 2'(LPWT_LOAD_TICKS - 1);
            end
        end else if (slow_rise) begin
            if (load_ticks == 2'h0) begin
                compare <= load_value;
                load_ready_bit <= 1'b1;
            end else begin
                load_ticks <= load_ticks - 2'h1;
            end
        end
    end

    // ==========================================================
    // Compare event, flag, DMA trigger and wake
    assign cmp_hit = running && (count == compare);
    assign cmp_event = cmp_hit && !cmp_prev;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmp_prev <= 1'b0;
            dma_trigger_o <= 1'b0;
            wake_request_o <= 1'b0;
        end else begin
            cmp_prev <= cmp_hit;
            dma_trigger_o <= cmp_event;
            wake_request_o <= cmp_event && (power_mode_i == LPWT_PM_ONE ||
                                            power_mode_i == LPWT_PM_TWO);
        end
    end

    // Set wins over a clear arriving in the same cycle.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wake_timer_irq_flag_o <= 1'b0;
            wake_timer_irq_o <= 1'b0;
        end else begin
            if (cmp_event) begin
                wake_timer_irq_flag_o <= 1'b1;
            end else if (wake_timer_irq_clear_i) begin
                wake_timer_irq_flag_o <= 1'b0;
            end
            wake_timer_irq_o <= (cmp_event || (wake_timer_irq_flag_o &&
                                 !wake_timer_irq_clear_i)) && wake_timer_irq_enable_i;
        end
    end

    // ==========================================================
    // Capture
    // Pin flags come from another block; they are synchronised before use.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= {pin_meta[1:0], pin_flag(cap_port, cap_pin, port0_pin_irq_flags_i,
                         port1_pin_irq_flags_i, port2_pin_irq_flags_i)};
            pin_sync <= {pin_sync[1:0], pin_meta[1]};
        end
    end

    // The flag must still be high at a slow edge, which sets pin_seen until the flag drops, so one capture fires.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_seen <= 1'b0;
        end else if (!pin_sync[1]) begin
            pin_seen <= 1'b0;
        end else if (slow_rise) begin
            pin_seen <= 1'b1;
        end
    end

    assign cap_event = slow_rise && pin_sync[1] && !pin_seen && !cap_valid &&
                       running;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cap_port <= LPWT_PORT_RESET;
            cap_pin <= LPWT_PIN_RESET;
        end else if (reg_wr_i && reg_addr_i == LPWT_OFF_CAP_SEL) begin
            cap_port <= reg_wdata_i[LPWT_PORT_LSB +: 2];
            cap_pin <= reg_wdata_i[2:0];
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            captured_value <= '0;
            cap_valid <= 1'b0;
        end else if (cap_event) begin
            captured_value <= count + 1'b1;
            cap_valid <= 1'b1;
        end else if (reg_wr_i && reg_addr_i == LPWT_OFF_CAP_STATE && !reg_wdata_i[0]) begin
            cap_valid <= 1'b0;
        end
    end

    // ==========================================================
    // Register read port
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= '0;
            slow_clock_level_bit_o <= 1'b0;
        end else begin
            slow_clock_level_bit_o <= slow_level;
            if (reg_rd_i) begin
                unique case (reg_addr_i)
                    LPWT_OFF_CNT_LOW: reg_rdata_o <= count[7:0];
                    LPWT_OFF_CNT_MID: reg_rdata_o <= snapshot[15:8];
                    LPWT_OFF_CNT_HIGH: reg_rdata_o <= snapshot[23:16];
                    LPWT_OFF_LOAD_STATE: reg_rdata_o <= {7'h00, load_ready_bit};
                    LPWT_OFF_CAP_SEL: reg_rdata_o <= {3'h0, cap_port, cap_pin};
                    LPWT_OFF_CAP_STATE: reg_rdata_o <= {7'h00, cap_valid};
                    LPWT_OFF_CAPV_LOW: reg_rdata_o <= captured_value[7:0];
                    LPWT_OFF_CAPV_MID: reg_rdata_o <= captured_value[15:8];
                    LPWT_OFF_CAPV_HIGH: reg_rdata_o <= captured_value[23:16];
                    default: reg_rdata_o <= 8'h00;
                endcase
            end
        end
    end
endmodule

// file: rtl/lpwt_pkg.sv
// Package with register map, field layout and reset values of the low power wake timer.
package lpwt_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [15:0] LPWT_OFF_CNT_LOW = 16'h0095;
    localparam logic [15:0] LPWT_OFF_CNT_MID = 16'h0096;
    localparam logic [15:0] LPWT_OFF_CNT_HIGH = 16'h0097;
    localparam logic [15:0] LPWT_OFF_LOAD_STATE = 16'h00AD;
    localparam logic [15:0] LPWT_OFF_CAP_SEL = 16'h62B0;
    localparam logic [15:0] LPWT_OFF_CAP_STATE = 16'h62B1;
    localparam logic [15:0] LPWT_OFF_CAPV_LOW = 16'h62B2;
    localparam logic [15:0] LPWT_OFF_CAPV_MID = 16'h62B3;
    localparam logic [15:0] LPWT_OFF_CAPV_HIGH = 16'h62B4;
    // ==========================================================
    // Widths, fields and reset values
    localparam int LPWT_CNT_W = 24;
    localparam logic [23:0] LPWT_CMP_RESET = 24'hFFFFFF;
    localparam logic [1:0] LPWT_PORT_RESET = 2'h3;
    localparam logic [2:0] LPWT_PIN_RESET = 3'h7;
    localparam logic [1:0] LPWT_PORT_OFF = 2'h3;
    localparam logic [1:0] LPWT_PORT_LAST_NARROW = 2'h2;
    localparam logic [2:0] LPWT_PIN_MAX_NARROW = 3'h5;
    localparam int LPWT_PORT_LSB = 3;
    localparam int LPWT_DMA_TRIGGER_NUM = 11;
    // Compare load takes this many slow ticks to complete.
    localparam int LPWT_LOAD_TICKS = 2;
    // ==========================================================
    // Power modes
    typedef enum logic [1:0] {
        LPWT_PM_ACTIVE,
        LPWT_PM_ONE,
        LPWT_PM_TWO,
        LPWT_PM_DEEPEST
    } lpwt_pmode_t;
endpackage

// file: rtl/lpwt_slow_edge.sv
// Two-stage synchroniser and rising edge detector for the slow clock.
`timescale 1ns/1ns
module lpwt_slow_edge (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic slow_clk_i,
    output logic level_o,
    output logic rise_o
);
    logic meta;
    logic sync;
    logic prev;

    // ==========================================================
    // Synchroniser and edge detection
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= slow_clk_i;
            sync <= meta;
            prev <= sync;
        end
    end

    assign level_o = sync;
    assign rise_o = sync & ~prev;
endmodule

// file: tb/lpwt_monitor.sv
// Port checker for the low power wake timer.
`timescale 1ns/1ns
module lpwt_monitor #(
    parameter int CNT_W = 24
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic slow_clk_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic [7:0] port0_pin_irq_flags_i,
    input wire logic [7:0] port1_pin_irq_flags_i,
    input wire logic [5:0] port2_pin_irq_flags_i,
    input wire lpwt_pkg::lpwt_pmode_t power_mode_i,
    input wire logic wake_timer_irq_enable_i,
    input wire logic wake_timer_irq_clear_i,
    input wire logic wake_timer_irq_flag_o,
    input wire logic wake_timer_irq_o,
    input wire logic dma_trigger_o,
    input wire logic wake_request_o,
    input wire logic slow_clock_level_bit_o
);
    import lpwt_pkg::*;
    // ==========================================================
    // Compare event, flag and read port
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    property p_dma_pulse; dma_trigger_o |=> !dma_trigger_o; endproperty
    a_dma_pulse: assert property (p_dma_pulse) else $error("dma pulse too long");
    property p_flag_set; dma_trigger_o |-> wake_timer_irq_flag_o; endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set");
    property p_flag_hold; wake_timer_irq_flag_o && !wake_timer_irq_clear_i |=> wake_timer_irq_flag_o;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag lost");
    property p_flag_clr; wake_timer_irq_clear_i |=> !wake_timer_irq_flag_o || dma_trigger_o;
    endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");
    property p_irq_off; !wake_timer_irq_enable_i [*2] |-> !wake_timer_irq_o; endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq not gated");
    property p_wake; wake_request_o |-> dma_trigger_o && power_mode_i inside {LPWT_PM_ONE, LPWT_PM_TWO};
    endproperty
    a_wake: assert property (p_wake) else $error("wake without cause");
    property p_rdata_hold; !reg_rd_i |=> $stable(reg_rdata_o); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    // The margin allows for the two synchroniser flops and the output register.
    property p_sync; $rose(slow_clk_i) |-> ##[1:5] $rose(slow_clock_level_bit_o); endproperty
    a_sync: assert property (p_sync) else $error("slow edge not seen");
endmodule

// file: tb/lpwt_top_test.sv
// Self-checking bench for the low power wake timer.
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module lpwt_top_test;
    import lpwt_pkg::*;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic slow_clk_i = 1'b0;
    logic [15:0] reg_addr_i = 16'h0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [7:0] port0_pin_irq_flags_i = 8'h00;
    logic [7:0] port1_pin_irq_flags_i = 8'h00;
    logic [5:0] port2_pin_irq_flags_i = 6'h00;
    lpwt_pmode_t power_mode_i = LPWT_PM_ACTIVE;
    logic wake_timer_irq_enable_i = 1'b0;
    logic wake_timer_irq_clear_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic wake_timer_irq_flag_o, wake_timer_irq_o, dma_trigger_o, wake_request_o;
    logic slow_clock_level_bit_o;
    logic [7:0] c, d;
    int n_errors = 0;
    int num_checks = 0;
    int k;
    lpwt_top lpwt_top_inst (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .slow_clk_i(slow_clk_i),
        .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o),
        .port0_pin_irq_flags_i(port0_pin_irq_flags_i),
        .port1_pin_irq_flags_i(port1_pin_irq_flags_i),
        .port2_pin_irq_flags_i(port2_pin_irq_flags_i),
        .power_mode_i(power_mode_i),
        .wake_timer_irq_enable_i(wake_timer_irq_enable_i),
        .wake_timer_irq_clear_i(wake_timer_irq_clear_i),
        .wake_timer_irq_flag_o(wake_timer_irq_flag_o),
        .wake_timer_irq_o(wake_timer_irq_o),
        .dma_trigger_o(dma_trigger_o),
        .wake_request_o(wake_request_o),
        .slow_clock_level_bit_o(slow_clock_level_bit_o)
    );
    initial forever #5 clk_i = ~clk_i;
    // The slow clock is sped up so a full low byte wrap fits in a short run.
    initial forever #110 slow_clk_i = ~slow_clk_i;
    // ==========================================================
    // Register access and waits
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        @(negedge clk_i);
        v = reg_rdata_o;
    endtask
    task automatic rc(input logic [15:0] a, input logic [7:0] e);
        rd(a, d);
        `CHK(d, e)
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        int j;
        repeat (n) begin
            j = 0;
            while (slow_clock_level_bit_o !== 1'b0 && j < 40) begin
                @(posedge clk_i);
                j++;
            end
            while (slow_clock_level_bit_o !== 1'b1 && j < 80) begin
                @(posedge clk_i);
                j++;
            end
            if (j >= 80) begin
                n_errors++;
                wrap_up();
            end
        end
        repeat (3) @(posedge clk_i);
    endtask
    // ==========================================================
    // Scenarios
    initial begin
        repeat (5) @(posedge clk_i);
        resetn_i <= 1'b1;
        rc(LPWT_OFF_LOAD_STATE, 8'h01);
        rc(LPWT_OFF_CAP_SEL, 8'h1F);
        rc(LPWT_OFF_CAP_STATE, 8'h00);
        rc(LPWT_OFF_CAPV_LOW, 8'h00);
        rc(16'h0098, 8'h00);
        tick(1);
        rd(LPWT_OFF_CNT_LOW, c);
        k = 0;
        while (c !== 8'hFF && k < 300) begin
            tick(1);
            rd(LPWT_OFF_CNT_LOW, d);
            `CHK(d, 8'(c + 8'h01))
            c = d;
            k++;
        end
        if (k >= 300) begin
            n_errors++;
            wrap_up();
        end
        tick(1);
        rc(LPWT_OFF_CNT_MID, 8'h00);
        rc(LPWT_OFF_CNT_LOW, 8'h00);
        rc(LPWT_OFF_CNT_MID, 8'h01);
        rc(LPWT_OFF_CNT_HIGH, 8'h00);
        @(posedge clk_i);
        power_mode_i <= LPWT_PM_ONE;
        wake_timer_irq_enable_i <= 1'b1;
        rd(LPWT_OFF_CNT_LOW, c);
        wr(LPWT_OFF_CNT_HIGH, 8'h00);
        wr(LPWT_OFF_CNT_MID, 8'h01);
        wr(LPWT_OFF_CNT_LOW, 8'(c + 8'h06));
        rc(LPWT_OFF_LOAD_STATE, 8'h00);
        wr(LPWT_OFF_CNT_LOW, 8'(c + 8'h03));
        k = 0;
        while (dma_trigger_o !== 1'b1 && k < 400) begin
            @(negedge clk_i);
            k++;
        end
        `CHK(dma_trigger_o, 1'b1)
        if (k >= 400) begin
            wrap_up();
        end
        `CHK(wake_request_o, 1'b1)
        `CHK(wake_timer_irq_flag_o, 1'b1)
        rc(LPWT_OFF_CNT_LOW, 8'(c + 8'h06));
        `CHK(wake_timer_irq_o, 1'b1)
        rc(LPWT_OFF_LOAD_STATE, 8'h01);
        @(posedge clk_i);
        wake_timer_irq_clear_i <= 1'b1;
        power_mode_i <= LPWT_PM_ACTIVE;
        @(posedge clk_i);
        wake_timer_irq_clear_i <= 1'b0;
        repeat (2) @(negedge clk_i);
        `CHK(wake_timer_irq_flag_o, 1'b0)
        wr(LPWT_OFF_CAP_SEL, 8'h0B);
        tick(1);
        rd(LPWT_OFF_CNT_LOW, c);
        @(posedge clk_i);
        port1_pin_irq_flags_i <= 8'h08;
        k = 0;
        d = 8'h00;
        while (d !== 8'h01 && k < 40) begin
            rd(LPWT_OFF_CAP_STATE, d);
            k++;
        end
        `CHK(d, 8'h01)
        if (k >= 40) begin
            wrap_up();
        end
        rc(LPWT_OFF_CAPV_LOW, 8'(c + 8'h01));
        rc(LPWT_OFF_CAPV_MID, 8'h01);
        wr(LPWT_OFF_CAP_STATE, 8'h01);
        rc(LPWT_OFF_CAP_STATE, 8'h01);
        wr(LPWT_OFF_CAP_STATE, 8'h00);
        tick(2);
        rc(LPWT_OFF_CAP_STATE, 8'h00);
        // Re-arm: valid is clear, the pin flag is cleared for one slow low-high, then set again.
        @(posedge clk_i);
        port1_pin_irq_flags_i <= 8'h00;
        tick(1);
        rd(LPWT_OFF_CNT_LOW, c);
        @(posedge clk_i);
        port1_pin_irq_flags_i <= 8'h08;
        k = 0;
        d = 8'h00;
        while (d !== 8'h01 && k < 40) begin
            rd(LPWT_OFF_CAP_STATE, d);
            k++;
        end
        `CHK(d, 8'h01)
        if (k >= 40) begin
            wrap_up();
        end
        rc(LPWT_OFF_CAPV_LOW, 8'(c + 8'h01));
        wr(LPWT_OFF_CAP_STATE, 8'h00);
        // Disable sequence before another pin is chosen.
        @(posedge clk_i);
        wake_timer_irq_enable_i <= 1'b0;
        tick(1);
        wr(LPWT_OFF_CAP_SEL, 8'h18);
        rc(LPWT_OFF_CAP_STATE, 8'h00);
        for (int i = 0; i < 2; i++) begin
            wr(LPWT_OFF_CAP_SEL, (i == 0) ? 8'h16 : 8'h1B);
            @(posedge clk_i);
            port0_pin_irq_flags_i <= 8'hFF;
            port1_pin_irq_flags_i <= 8'hFF;
            port2_pin_irq_flags_i <= 6'h3F;
            tick(2);
            rc(LPWT_OFF_CAP_STATE, 8'h00);
            @(posedge clk_i);
            port0_pin_irq_flags_i <= 8'h00;
            port1_pin_irq_flags_i <= 8'h00;
            port2_pin_irq_flags_i <= 6'h00;
            tick(1);
        end
        @(posedge clk_i);
        power_mode_i <= LPWT_PM_DEEPEST;
        repeat (60) @(posedge clk_i);
        rc(LPWT_OFF_CNT_LOW, 8'h00);
        wrap_up();
    end
endmodule
bind lpwt_top lpwt_monitor #(.CNT_W(CNT_W)) lpwt_monitor_inst (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .slow_clk_i(slow_clk_i),
    .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o),
    .port0_pin_irq_flags_i(port0_pin_irq_flags_i),
    .port1_pin_irq_flags_i(port1_pin_irq_flags_i),
    .port2_pin_irq_flags_i(port2_pin_irq_flags_i),
    .power_mode_i(power_mode_i),
    .wake_timer_irq_enable_i(wake_timer_irq_enable_i),
    .wake_timer_irq_clear_i(wake_timer_irq_clear_i),
    .wake_timer_irq_flag_o(wake_timer_irq_flag_o),
    .wake_timer_irq_o(wake_timer_irq_o),
    .dma_trigger_o(dma_trigger_o),
    .wake_request_o(wake_request_o),
    .slow_clock_level_bit_o(slow_clock_level_bit_o)
);
